// ---- rtl/rpcfg_cmd.v ----
`timescale 1ns/1ps
`include "rpcfg_map.vh"
// Contract
// (RULE1) read-only vendor code at offset zero
// (RULE2) read-only part code varies per function and link mode; code tracks link mode only when dev_sel is 0, function only otherwise
// (RULE3) interrupt disable bit set suppresses legacy interrupts
// (RULE4) interrupt disable never blocks routing of downstream interrupt messages
// (RULE5) interrupt disable gates error, root error message, hotplug and power interrupts
// (RULE6) unused legacy command bits read zero and ignore writes
// (RULE7) error report enable lets detected uncorrectable errors reach core logic
// (RULE8) error report enable also gates forwarded fatal and nonfatal messages
// (RULE9) error report enable clear: nothing fatal or nonfatal reaches core logic
// (RULE10) parity checking always runs regardless of parity response bit
// (RULE11) parity response bit qualifies the master data parity flag
// (RULE12) memory enable set: memory ranges decode secondary accesses
// (RULE13) memory enable clear: every secondary memory access gets unsupported request
// (RULE14) io accesses answered only while io enable set
// (RULE15) all writable command bits reset to zero
// (RULE16) parity flag set only with parity response on and poisoned data
// (RULE17) legacy interrupt sent only when not disabled and status pending
// (RULE18) system error flag set only when reporting with report enable set
// (RULE19) bus master enable clear blocks upstream requests from secondary side
// (RULE20) locked variants ignore writes to master, memory and io enables
module rpcfg_cmd (
   input wire clock,
   input wire srst,
   // configuration access
   input wire cfg_rd,
   input wire cfg_wr,
   input wire [11:0] cfg_addr,
   input wire [1:0] cfg_be,
   input wire [15:0] cfg_wdata,
   output reg [15:0] cfg_rdata,
   output reg cfg_ack,
   // identity straps
   input wire [1:0] func_num,
   input wire [1:0] dev_sel,
   input wire link_mode,
   input wire lockable,
   input wire cfg_lock,
   // interrupt sources
   input wire int_port_err,
   input wire int_rp_msg,
   input wire int_hp_pm,
   input wire msi_in,
   output reg intx_assert,
   output reg msi_route,
   // error sources
   input wire unc_err_det,
   input wire err_msg_rx,
   input wire poison_rx,
   input wire poison_fwd,
   input wire parity_err_det,
   output reg core_err_notify,
   output reg parity_err_sig,
   // secondary memory and io
   input wire mem_req,
   input wire mem_hit,
   input wire io_req,
   input wire io_hit,
   output reg mem_accept,
   output reg mem_ur,
   output reg io_accept,
   output reg io_ur,
   // upstream mastering
   input wire up_req,
   output reg up_grant,
   // live controls
   output reg [15:0] command_out,
   output reg [15:0] status_out
);
   reg [15:0] command_reg;
   reg [15:0] command_next;
   reg intx_pend_reg;
   reg mdpe_reg;
   reg sse_reg;
   wire [15:0] part_code;
   wire perre;
   wire serre;
   wire [15:0] status_view;
   wire [15:0] wmask;
   wire err_report;

   rpcfg_part_sel u_part (
      .func_num(func_num),
      .dev_sel(dev_sel),
      .link_mode(link_mode),
      .part_code(part_code) // RULE2
   );

   function hit;
      input [11:0] addr;
      input [11:0] off;
      begin
         hit = (addr[11:1] == off[11:1]);
      end
   endfunction

   assign perre = command_reg[`RPCFG_CMD_PERRE];
   assign serre = command_reg[`RPCFG_CMD_SERRE];
   // locked bits drop out of the write mask rather than being restored later
   assign wmask = (lockable && cfg_lock) ?
                  (`RPCFG_CMD_WMASK & ~`RPCFG_CMD_LMASK) : `RPCFG_CMD_WMASK; // RULE20 RULE6
   assign err_report = serre & (unc_err_det | err_msg_rx); // RULE7 RULE8 RULE9
   assign status_view = {1'b0, sse_reg, 5'h00, mdpe_reg, 4'h0, intx_pend_reg, 3'h0};

   always @* begin
      command_next = command_reg;
      if (cfg_wr && hit(cfg_addr, `RPCFG_OFF_COMMAND)) begin
         if (cfg_be[0])
            command_next[7:0] = (cfg_wdata[7:0] & wmask[7:0]) | (command_reg[7:0] & ~wmask[7:0]);
         if (cfg_be[1])
            command_next[15:8] = (cfg_wdata[15:8] & wmask[15:8]) |
                                 (command_reg[15:8] & ~wmask[15:8]);
      end
   end

   always @(posedge clock) begin
      if (srst) begin
         command_reg <= `RPCFG_CMD_RESET; // RULE15
         intx_pend_reg <= 1'b0;
         mdpe_reg <= 1'b0;
         sse_reg <= 1'b0;
         cfg_rdata <= 16'h0000;
         cfg_ack <= 1'b0;
         intx_assert <= 1'b0;
         msi_route <= 1'b0;
         core_err_notify <= 1'b0;
         parity_err_sig <= 1'b0;
         mem_accept <= 1'b0;
         mem_ur <= 1'b0;
         io_accept <= 1'b0;
         io_ur <= 1'b0;
         up_grant <= 1'b0;
         command_out <= `RPCFG_CMD_RESET;
         status_out <= 16'h0000;
      end else begin
         command_reg <= command_next;
         // pending interrupt is independent of the disable bit
         intx_pend_reg <= int_port_err | int_rp_msg | int_hp_pm; // RULE5
         // set wins over a write-one-to-clear in the same cycle
         if (perre && (poison_rx || poison_fwd))
            mdpe_reg <= 1'b1; // RULE11 RULE16
         else if (cfg_wr && cfg_be[1] && hit(cfg_addr, `RPCFG_OFF_STATUS) &&
                  cfg_wdata[`RPCFG_STS_MDPE])
            mdpe_reg <= 1'b0;
         if (err_report)
            sse_reg <= 1'b1; // RULE18
         else if (cfg_wr && cfg_be[1] && hit(cfg_addr, `RPCFG_OFF_STATUS) &&
                  cfg_wdata[`RPCFG_STS_SSE])
            sse_reg <= 1'b0;
         cfg_ack <= cfg_rd | cfg_wr;
         if (cfg_rd) begin
            if (hit(cfg_addr, `RPCFG_OFF_VENDOR))
               cfg_rdata <= `RPCFG_VENDOR_CODE; // RULE1
            else if (hit(cfg_addr, `RPCFG_OFF_PART))
               cfg_rdata <= part_code; // RULE2
            else if (hit(cfg_addr, `RPCFG_OFF_COMMAND))
               cfg_rdata <= command_reg; // RULE6
            else if (hit(cfg_addr, `RPCFG_OFF_STATUS))
               cfg_rdata <= status_view;
            else
               cfg_rdata <= 16'h0000;
         end
         intx_assert <= ~command_reg[`RPCFG_CMD_INTDIS] & intx_pend_reg; // RULE3 RULE17
         msi_route <= msi_in; // RULE4
         core_err_notify <= err_report; // RULE7 RULE8 RULE9
         parity_err_sig <= parity_err_det; // RULE10
         mem_accept <= mem_req & mem_hit & command_reg[`RPCFG_CMD_MSE]; // RULE12
         mem_ur <= mem_req & ~command_reg[`RPCFG_CMD_MSE]; // RULE13
         io_accept <= io_req & io_hit & command_reg[`RPCFG_CMD_IOSE]; // RULE14
         io_ur <= io_req & ~command_reg[`RPCFG_CMD_IOSE]; // RULE14
         up_grant <= up_req & command_reg[`RPCFG_CMD_BME]; // RULE19
         command_out <= command_reg;
         status_out <= status_view;
      end
   end
endmodule

// ---- rtl/rpcfg_map.vh ----
`ifndef RPCFG_MAP_VH
`define RPCFG_MAP_VH
// configuration offsets (byte addresses within the function's space)
`define RPCFG_OFF_VENDOR 12'h000
`define RPCFG_OFF_PART 12'h002
`define RPCFG_OFF_COMMAND 12'h004
`define RPCFG_OFF_STATUS 12'h006
// command bit positions
`define RPCFG_CMD_IOSE 0
`define RPCFG_CMD_MSE 1
`define RPCFG_CMD_BME 2
`define RPCFG_CMD_PERRE 6
`define RPCFG_CMD_SERRE 8
`define RPCFG_CMD_INTDIS 10
// writable command bits and reset value
`define RPCFG_CMD_WMASK 16'h0547
`define RPCFG_CMD_LMASK 16'h0007
`define RPCFG_CMD_RESET 16'h0000
// status bit positions
`define RPCFG_STS_INTX 3
`define RPCFG_STS_MDPE 8
`define RPCFG_STS_SSE 14
// identity codes (arbitrary values)
`define RPCFG_VENDOR_CODE 16'h1AB5
`define RPCFG_PART_BASE 16'h5A10
`endif

// ---- rtl/rpcfg_part_sel.v ----
`timescale 1ns/1ps
`include "rpcfg_map.vh"
// picks the part code for this port function
module rpcfg_part_sel (
   // strap inputs
   input wire [1:0] func_num,
   input wire [1:0] dev_sel,
   input wire link_mode,
   // result
   output reg [15:0] part_code
);
   always @* begin
      case (dev_sel)
         2'h0: part_code = `RPCFG_PART_BASE + {15'h0000, ~link_mode};
         2'h1: part_code = `RPCFG_PART_BASE + 16'h0004 + {14'h0000, func_num};
         default: part_code = `RPCFG_PART_BASE + 16'h0008 + {14'h0000, func_num};
      endcase
   end
endmodule

// ---- testbench/rpcfg_cmd_sva.sv ----
`timescale 1ns/1ps
module rpcfg_cmd_chk (
   // clock and reset
   input wire clock,
   input wire srst,
   // causes
   input wire msi_in,
   input wire unc_err_det,
   input wire err_msg_rx,
   input wire mem_req,
   input wire up_req,
   input wire parity_err_det,
   input wire cfg_rd,
   input wire cfg_wr,
   input wire io_req,
   // effects
   input wire cfg_ack,
   input wire io_ur,
   input wire msi_route,
   input wire core_err_notify,
   input wire intx_assert,
   input wire mem_accept,
   input wire mem_ur,
   input wire io_accept,
   input wire up_grant,
   input wire parity_err_sig,
   input wire [15:0] command_out,
   input wire [15:0] status_out
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   // command_out lags the live register, so it lines up with one-cycle side outputs
   sequence s_err_seen;
      (unc_err_det || err_msg_rx) && !srst ##1 command_out[8];
   endsequence
   a_msi_ungated: assert property (!$past(srst) |-> msi_route == $past(msi_in))
      else $error("msi route differs");
   a_err_notify: assert property (s_err_seen |-> core_err_notify)
      else $error("error not notified");
   a_err_blocked: assert property (core_err_notify |-> command_out[8])
      else $error("error notified while disabled");
   a_intx_gate: assert property (intx_assert |-> !command_out[10])
      else $error("intx while disabled");
   a_mem_refused: assert property (!$past(srst) && $past(mem_req) && !command_out[1]
      |-> mem_ur && !mem_accept)
      else $error("memory not refused");
   a_mem_decode: assert property (mem_accept |-> command_out[1])
      else $error("memory accepted while off");
   a_io_gate: assert property (io_accept |-> command_out[0])
      else $error("io accepted while off");
   a_io_refused: assert property (!$past(srst) |-> io_ur == ($past(io_req) && !command_out[0]))
      else $error("io refusal mismatch");
   a_ack_pulse: assert property (!$past(srst) |-> cfg_ack == ($past(cfg_rd) || $past(cfg_wr)))
      else $error("ack not one cycle after request");
   a_master_gate: assert property (!$past(srst) |-> up_grant == ($past(up_req) && command_out[2]))
      else $error("grant mismatch");
   a_parity_always: assert property (!$past(srst) && $past(parity_err_det) |-> parity_err_sig)
      else $error("parity not signalled");
   a_mdpe_qual: assert property ($rose(status_out[8]) |-> $past(command_out[6]))
      else $error("parity flag without response");
   a_ro_zero: assert property ((command_out & 16'hFAB8) == 16'h0000)
      else $error("read-only command bit set");
endmodule
bind rpcfg_cmd rpcfg_cmd_chk u_chk (.clock, .srst, .msi_in, .unc_err_det, .err_msg_rx, .mem_req,
   .up_req, .parity_err_det, .cfg_rd, .cfg_wr, .io_req, .cfg_ack, .io_ur, .msi_route,
   .core_err_notify, .intx_assert, .mem_accept, .mem_ur,
   .io_accept, .up_grant, .parity_err_sig, .command_out, .status_out);

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`include "rpcfg_map.vh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb;
   logic clock = 0, srst = 1, cfg_rd = 0, cfg_wr = 0, link_mode = 0, lockable = 0, cfg_lock = 0;
   logic [11:0] cfg_addr = 0;
   logic [1:0] cfg_be = 0, func_num = 0, dev_sel = 0;
   logic [15:0] cfg_wdata = 0, cfg_rdata, command_out, status_out, d;
   logic [13:0] ev = 0;
   logic cfg_ack, intx_assert, msi_route, core_err_notify, parity_err_sig;
   logic mem_accept, mem_ur, io_accept, io_ur, up_grant;
   integer seed = 32'h9406, failures = 0, num_checks = 0, i;
   always #12.5 clock = ~clock;
   rpcfg_cmd u_dut (.clock, .srst, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata,
      .cfg_ack, .func_num, .dev_sel, .link_mode, .lockable, .cfg_lock, .int_port_err(ev[0]),
      .int_rp_msg(ev[1]), .int_hp_pm(ev[2]), .msi_in(ev[3]), .intx_assert, .msi_route,
      .unc_err_det(ev[4]), .err_msg_rx(ev[5]), .poison_rx(ev[6]), .poison_fwd(ev[7]),
      .parity_err_det(ev[8]), .core_err_notify, .parity_err_sig, .mem_req(ev[9]),
      .mem_hit(ev[10]), .io_req(ev[11]), .io_hit(ev[12]), .mem_accept, .mem_ur, .io_accept,
      .io_ur, .up_req(ev[13]), .up_grant, .command_out, .status_out);
   // s is {link_mode, dev_sel, func_num}
   function logic [15:0] exp_part(input logic [4:0] s);
      if (s[3:2] == 2'h0) exp_part = `RPCFG_PART_BASE + (s[4] ? 16'h0000 : 16'h0001);
      else exp_part = `RPCFG_PART_BASE + (s[3:2] == 2'h1 ? 16'h0004 : 16'h0008) + s[1:0];
   endfunction
   task cfg(input logic wr, input logic [11:0] a, input logic [15:0] v);
      @(negedge clock);
      {cfg_wr, cfg_rd, cfg_addr, cfg_wdata, cfg_be} = {wr, !wr, a, v, 2'h3};
      @(negedge clock);
      {cfg_wr, cfg_rd} = 2'h0;
   endtask
   task rd(input logic [11:0] a, input logic [15:0] e);
      cfg(1'b0, a, 16'h0000);
      `CHK("rdata", e, cfg_rdata)
   endtask
   task results;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      #100000;
      failures++;
      results();
   end
   initial begin
      repeat (2) @(negedge clock);
      srst = 0;
      rd(12'h004, 16'h0000);
      cfg(1'b1, 12'h000, 16'hFFFF);
      rd(12'h000, `RPCFG_VENDOR_CODE);
      cfg(1'b1, 12'h004, 16'hFFFF);
      rd(12'h004, `RPCFG_CMD_WMASK);
      rd(12'h0F0, 16'h0000);
      {lockable, cfg_lock} = 2'h3;
      cfg(1'b1, 12'h004, 16'h0000);
      rd(12'h004, 16'h0007);
      {lockable, cfg_lock} = 2'h0;
      // status flags: set with both qualifiers on, then cleared by writing ones
      cfg(1'b1, 12'h004, 16'h0140);
      @(negedge clock);
      ev = 14'h0050;
      @(negedge clock);
      ev = 14'h0000;
      rd(12'h006, 16'h4100);
      cfg(1'b1, 12'h006, 16'hFFFF);
      rd(12'h006, 16'h0000);
      cfg(1'b1, 12'h004, 16'h0000);
      ev = 14'h0001;
      repeat (3) @(negedge clock);
      `CHK("intx", 1'b1, intx_assert)
      cfg(1'b1, 12'h004, 16'h0400);
      repeat (2) @(negedge clock);
      `CHK("intx", 1'b0, intx_assert)
      rd(12'h006, 16'h0008);
      ev = 14'h0000;
      for (i = 0; i < 32; i++) begin
         {link_mode, dev_sel, func_num} = i[4:0];
         rd(12'h002, exp_part(i[4:0]));
      end
      // random traffic keeps every gate toggling under live events
      for (i = 0; i < 400; i++) begin
         @(negedge clock);
         ev = $random(seed);
         d = $random(seed);
         if (i % 16 == 4) cfg(1'b1, 12'h006, 16'hFFFF);
         if (i % 8 == 0) begin
            cfg(1'b1, 12'h004, d);
            rd(12'h004, d & `RPCFG_CMD_WMASK);
         end
      end
      results();
   end
endmodule
